// >>> bss_decode.sv
// ************************************************************
// Shared constants and types
// ************************************************************
package bss_pkg;

    localparam int          STRAP_W          = 4;
    localparam int          CODE_W           = 4;

    // Boot-source field codes
    localparam logic [3:0]  CODE_PIN_STATE   = 4'h0;
    localparam logic [3:0]  CODE_UART_FIRST  = 4'h1;
    localparam logic [3:0]  CODE_QUAD_FLASH  = 4'h2;
    localparam logic [3:0]  CODE_STATIC8     = 4'h3;
    localparam logic [3:0]  CODE_STATIC16    = 4'h4;
    localparam logic [3:0]  CODE_STATIC32    = 4'h5;
    localparam logic [3:0]  CODE_USB_FIRST   = 4'h6;
    localparam logic [3:0]  CODE_USB_SECOND  = 4'h7;
    localparam logic [3:0]  CODE_SYNC_SERIAL = 4'h8;
    localparam logic [3:0]  CODE_UART_FOURTH = 4'h9;

    // Strap patterns, bit3 down to bit0
    localparam logic [3:0]  PAT_UART_FIRST   = 4'h0;
    localparam logic [3:0]  PAT_QUAD_FLASH   = 4'h1;
    localparam logic [3:0]  PAT_STATIC8      = 4'h2;
    localparam logic [3:0]  PAT_STATIC16     = 4'h3;
    localparam logic [3:0]  PAT_STATIC32     = 4'h4;
    localparam logic [3:0]  PAT_USB_FIRST    = 4'h5;

    // Boot ROM address space
    localparam int          ROM_SIZE_KB      = 64;
    localparam int          ROM_SIZE_W       = 17;
    localparam logic [16:0] ROM_SIZE_BYTES   = 17'(ROM_SIZE_KB * 1024);

    // Settle time after reset release before sampling
    localparam int          SETTLE_CYCLES    = 4;
    localparam logic [2:0]  SETTLE_LAST      = 3'(SETTLE_CYCLES - 1);

    // Reset values of outputs
    localparam logic        RST_FETCH_ROM    = 1'b1;

    typedef enum logic [3:0] {
        SRC_NONE,
        SRC_UART_FIRST,
        SRC_QUAD_FLASH,
        SRC_STATIC8,
        SRC_STATIC16,
        SRC_STATIC32,
        SRC_USB_FIRST,
        SRC_USB_SECOND,
        SRC_SYNC_SERIAL,
        SRC_UART_FOURTH,
        SRC_UNDEF
    } bss_src_e;

    typedef enum {
        ST_SETTLE,
        ST_CAPTURE,
        ST_DONE
    } bss_state_e;

endpackage

// ************************************************************
// Boot source decoder
// ************************************************************
module bss_decode
    import bss_pkg::*;
(
    input  wire logic [3:0] field,
    input  wire logic       otp_programmed,
    input  wire logic       enable_strap_n,
    input  wire logic [3:0] strap,
    output bss_src_e        src,
    output logic            pin_mode
);

    // Same table serves the field and the shifted strap pattern
    function automatic bss_src_e src_of_code(input logic [3:0] code);
        bss_src_e s;
        s = SRC_UNDEF;
        case (code)
            CODE_UART_FIRST:  s = SRC_UART_FIRST;
            CODE_UART_FOURTH: s = SRC_UART_FOURTH;
            CODE_QUAD_FLASH:  s = SRC_QUAD_FLASH;
            CODE_STATIC8:     s = SRC_STATIC8;
            CODE_STATIC16:    s = SRC_STATIC16;
            CODE_STATIC32:    s = SRC_STATIC32;
            CODE_USB_FIRST:   s = SRC_USB_FIRST;
            CODE_USB_SECOND:  s = SRC_USB_SECOND;
            CODE_SYNC_SERIAL: s = SRC_SYNC_SERIAL;
            default:          s = SRC_UNDEF;
        endcase
        return s;
    endfunction

    always_comb begin
        pin_mode = !otp_programmed || (field == CODE_PIN_STATE);
        if (enable_strap_n) begin
            src      = SRC_NONE;
            pin_mode = 1'b0;
        end else if (pin_mode) begin
            // Listed patterns map one step below their field code
            if (strap <= PAT_USB_FIRST) begin
                src = src_of_code(4'(strap + 4'h1));
            end else begin
                src = SRC_UNDEF;
            end
        end else begin
            src = src_of_code(field);
        end
    end

endmodule

// >>> bss_top.sv
// Behaviour
// - After any reset, instruction fetch starts from the internal boot ROM only.
// - Boot ROM provides 64 kB of address space.
// - Selectable modes apply only with enable strap low; field then chooses.
// - Unprogrammed OTP or zero field means strap pins choose the source.
// - Field code 0000 selects pin-state mode.
// - Code 0001 selects first UART programming, 1001 fourth UART programming.
// - Code 0010 selects quad SPI flash boot on the quad flash interface.
// - Codes 0011, 0100, 0101 select static memory, 8, 16, 32 bits wide.
// - Code 0110 selects first USB port, 0111 the second USB port.
// - Code 1000 selects SPI flash on the first synchronous serial port.
// - Pin functions differ for serial port boot and quad flash boot.
// - Straps 0000 select first UART, 0001 select quad flash boot.
// - Straps 0010, 0011, 0100 select 8, 16, 32-bit static memory.
// - Straps 0101 select first USB port boot.
module bss_top
    import bss_pkg::*;
(
    input  wire logic                  CLK_SYS,
    input  wire logic                  ARST_N,
    input  wire logic                  BOOT_MODE_ENABLE_STRAP,
    input  wire logic                  STRAP_BIT3,
    input  wire logic                  STRAP_BIT2,
    input  wire logic                  STRAP_BIT1,
    input  wire logic                  STRAP_BIT0,
    input  wire logic [3:0]            BOOT_SOURCE_FIELD,
    input  wire logic                  OTP_PROGRAMMED,
    output logic      [3:0]            BOOT_SOURCE,
    output logic                       BOOT_SEL_VALID,
    output logic                       BOOT_SEL_UNDEFINED,
    output logic                       BOOT_MODES_ENABLED,
    output logic                       BOOT_PIN_STATE_MODE,
    output logic                       FETCH_FROM_BOOT_ROM,
    output logic      [ROM_SIZE_W-1:0] BOOT_ROM_SIZE,
    output logic                       PINFUNC_SYNC_SERIAL,
    output logic                       PINFUNC_QUAD_FLASH
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [4:0]  pins_meta_r;
    logic [4:0]  pins_sync_r;
    bss_state_e  state_r;
    bss_state_e  state_nxt;
    logic [2:0]  settle_r;
    bss_src_e    dec_src;
    logic        dec_pin_mode;

    // Straps are asynchronous pads; two flops before any use
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            pins_meta_r <= 5'h00;
            pins_sync_r <= 5'h00;
        end else begin
            pins_meta_r <= {BOOT_MODE_ENABLE_STRAP, STRAP_BIT3, STRAP_BIT2,
                            STRAP_BIT1, STRAP_BIT0};
            pins_sync_r <= pins_meta_r;
        end
    end

    // ************************************************************
    // Decode
    // ************************************************************
    bss_decode u_decode (
        .field          (BOOT_SOURCE_FIELD),
        .otp_programmed (OTP_PROGRAMMED),
        .enable_strap_n (pins_sync_r[4]),
        .strap          (pins_sync_r[3:0]),
        .src            (dec_src),
        .pin_mode       (dec_pin_mode)
    );

    // ************************************************************
    // Capture sequence
    // ************************************************************
    // Settle covers the synchroniser latency plus pad pull-up margin
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_SETTLE: begin
                if (settle_r == SETTLE_LAST) begin
                    state_nxt = ST_CAPTURE;
                end
            end
            ST_CAPTURE: state_nxt = ST_DONE;
            ST_DONE:    state_nxt = ST_DONE;
            default:    state_nxt = ST_SETTLE;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= ST_SETTLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            settle_r <= 3'h0;
        end else if (state_r == ST_SETTLE) begin
            settle_r <= 3'(settle_r + 3'h1);
        end
    end

    // ************************************************************
    // Captured selection
    // ************************************************************
    // Loaded only in the capture state; later pin or OTP motion is ignored
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            BOOT_SOURCE         <= 4'h0;
            BOOT_SEL_UNDEFINED  <= 1'b0;
            BOOT_MODES_ENABLED  <= 1'b0;
            BOOT_PIN_STATE_MODE <= 1'b0;
            PINFUNC_SYNC_SERIAL <= 1'b0;
            PINFUNC_QUAD_FLASH  <= 1'b0;
        end else if (state_r == ST_CAPTURE) begin
            BOOT_SOURCE         <= 4'(dec_src);
            BOOT_SEL_UNDEFINED  <= (dec_src == SRC_UNDEF);
            BOOT_MODES_ENABLED  <= !pins_sync_r[4];
            BOOT_PIN_STATE_MODE <= dec_pin_mode;
            PINFUNC_SYNC_SERIAL <= (dec_src == SRC_SYNC_SERIAL);
            PINFUNC_QUAD_FLASH  <= (dec_src == SRC_QUAD_FLASH);
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            BOOT_SEL_VALID <= 1'b0;
        end else begin
            BOOT_SEL_VALID <= (state_r == ST_CAPTURE) || BOOT_SEL_VALID;
        end
    end

    // ************************************************************
    // Boot ROM fetch window
    // ************************************************************
    // No path ever redirects fetch; other memories are left to the boot code
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            FETCH_FROM_BOOT_ROM <= RST_FETCH_ROM;
            BOOT_ROM_SIZE       <= ROM_SIZE_BYTES;
        end else begin
            FETCH_FROM_BOOT_ROM <= RST_FETCH_ROM;
            BOOT_ROM_SIZE       <= ROM_SIZE_BYTES;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    wire logic cap_w = (state_r == ST_CAPTURE);
    wire logic cap_field_w = cap_w && !pins_sync_r[4] && !dec_pin_mode;
    wire logic cap_pins_w = cap_w && !pins_sync_r[4] && dec_pin_mode;

    a_rom_fetch_only: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        FETCH_FROM_BOOT_ROM && !$changed(FETCH_FROM_BOOT_ROM))
        else $error("fetch left boot ROM");

    a_rom_size_fixed: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        BOOT_ROM_SIZE == 17'h10000)
        else $error("boot ROM size wrong");

    a_modes_gated_off: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        cap_w && pins_sync_r[4] |=> BOOT_SOURCE == 4'h0 && !BOOT_MODES_ENABLED
            && !BOOT_PIN_STATE_MODE)
        else $error("modes active with enable strap high");

    a_pin_mode_entry: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        cap_w && !pins_sync_r[4] && (!OTP_PROGRAMMED || BOOT_SOURCE_FIELD == 4'h0)
            |=> BOOT_PIN_STATE_MODE)
        else $error("pin-state mode not entered");

    a_field_uart_map: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        cap_field_w && (BOOT_SOURCE_FIELD == 4'h1 || BOOT_SOURCE_FIELD == 4'h9)
            |=> BOOT_SOURCE == $past(BOOT_SOURCE_FIELD) && !BOOT_SEL_UNDEFINED
            && !PINFUNC_SYNC_SERIAL && !PINFUNC_QUAD_FLASH)
        else $error("UART code misdecoded");

    a_field_code_map: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        cap_field_w && BOOT_SOURCE_FIELD inside {[4'h2:4'h8]}
            |=> BOOT_SOURCE == $past(BOOT_SOURCE_FIELD) && !BOOT_SEL_UNDEFINED)
        else $error("field code misdecoded");

    a_strap_map: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        cap_pins_w && pins_sync_r[3:0] <= 4'h5
            |=> BOOT_SOURCE == 4'($past(pins_sync_r[3:0]) + 4'h1))
        else $error("strap pattern misdecoded");

    a_undef_flagged: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (cap_field_w && BOOT_SOURCE_FIELD > 4'h9) || (cap_pins_w && pins_sync_r[3:0] > 4'h5)
            |=> BOOT_SEL_UNDEFINED && BOOT_SOURCE == 4'hA)
        else $error("undefined selection not flagged");

    a_pinfunc_excl: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        !(PINFUNC_SYNC_SERIAL && PINFUNC_QUAD_FLASH)
            && PINFUNC_SYNC_SERIAL == (BOOT_SOURCE == 4'h8)
            && PINFUNC_QUAD_FLASH == (BOOT_SOURCE == 4'h2))
        else $error("pin function mismatch");

    a_valid_bound: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        !BOOT_SEL_VALID |-> ##[1:6] BOOT_SEL_VALID)
        else $error("selection never captured");

    a_frozen_after: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        BOOT_SEL_VALID |=> BOOT_SEL_VALID && $stable(BOOT_SOURCE)
            && $stable(BOOT_SEL_UNDEFINED) && $stable(BOOT_PIN_STATE_MODE))
        else $error("selection changed after capture");

endmodule

// >>> bss_fw_model.sv
// ****************************************
// Boot firmware model
// ****************************************
module bss_fw_model
    import bss_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [3:0] boot_source,
    input  wire logic       sel_valid,
    input  wire logic       pf_sync,
    input  wire logic       pf_quad,
    output logic      [3:0] fw_src,
    output logic            fw_pin_ok
);
    timeunit 1ns;
    timeprecision 1ps;

    logic taken_r;

    // Read once; later changes would mean a moving boot target
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            taken_r   <= 1'b0;
            fw_src    <= 4'h0;
            fw_pin_ok <= 1'b0;
        end else if (sel_valid && !taken_r) begin
            taken_r   <= 1'b1;
            fw_src    <= boot_source;
            fw_pin_ok <= (pf_sync == (boot_source == CODE_SYNC_SERIAL)) &&
                         (pf_quad == (boot_source == CODE_QUAD_FLASH)) &&
                         !(pf_sync && pf_quad);
        end
    end
endmodule

// >>> tb_bss_top.sv
// ****************************************
// Testbench
// ****************************************
module tb_bss_top
    import bss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CYCLE_LIMIT = 3000;

    logic        clk_sys = 1'b0;
    logic        arst_n  = 1'b0;
    logic        en_s    = 1'b1;
    logic [3:0]  strap   = 4'h0;
    logic [3:0]  field   = 4'h0;
    logic        otp_p   = 1'b0;
    logic [3:0]  boot_source_field;
    logic        sel_valid;
    logic        sel_undef;
    logic        modes_en;
    logic        pin_mode;
    logic        fetch_rom;
    logic [16:0] rom_size;
    logic        pf_sync;
    logic        pf_quad;
    logic [3:0]  fw_src;
    logic        fw_ok;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cycles     = 0;

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    bss_top bss_top_inst (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .BOOT_MODE_ENABLE_STRAP(en_s),
        .STRAP_BIT3(strap[3]), .STRAP_BIT2(strap[2]), .STRAP_BIT1(strap[1]),
        .STRAP_BIT0(strap[0]), .BOOT_SOURCE_FIELD(field), .OTP_PROGRAMMED(otp_p),
        .BOOT_SOURCE(boot_source_field), .BOOT_SEL_VALID(sel_valid),
        .BOOT_SEL_UNDEFINED(sel_undef), .BOOT_MODES_ENABLED(modes_en),
        .BOOT_PIN_STATE_MODE(pin_mode), .FETCH_FROM_BOOT_ROM(fetch_rom),
        .BOOT_ROM_SIZE(rom_size), .PINFUNC_SYNC_SERIAL(pf_sync),
        .PINFUNC_QUAD_FLASH(pf_quad)
    );

    bss_fw_model bss_fw_model_inst (
        .clk(clk_sys), .arst_n(arst_n), .boot_source(boot_source_field),
        .sel_valid(sel_valid), .pf_sync(pf_sync), .pf_quad(pf_quad),
        .fw_src(fw_src), .fw_pin_ok(fw_ok)
    );

    // ****************************************
    // Expectation and compare helpers
    // ****************************************
    function automatic logic [3:0] exp_src(input logic en, input logic otp,
                                           input logic [3:0] fld, input logic [3:0] st);
        if (en) return 4'h0;
        if (!otp || fld == 4'h0) return (st <= 4'h5) ? st + 4'h1 : 4'hA;
        return (fld <= 4'h9) ? fld : 4'hA;
    endfunction

    task automatic chk_src(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected source at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [16:0] got, input logic [16:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected size at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_sel(input logic [3:0] es, input logic en, input logic pm);
        chk_src(boot_source_field, es);
        chk_flag(sel_valid, 1'b1);
        chk_flag(sel_undef, es == 4'hA);
        chk_flag(modes_en, !en);
        chk_flag(pin_mode, pm);
        chk_flag(pf_sync, es == 4'h8);
        chk_flag(pf_quad, es == 4'h2);
        chk_flag(fetch_rom, 1'b1);
    endtask

    // Every case starts with a reset, so each case after the first is also a mid-run reset
    task automatic run_case(input logic en, input logic otp,
                            input logic [3:0] fld, input logic [3:0] st);
        logic [3:0] es;
        logic       pm;
        es = exp_src(en, otp, fld, st);
        pm = !en && (!otp || fld == 4'h0);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        en_s   <= en;
        otp_p  <= otp;
        field  <= fld;
        strap  <= st;
        repeat (2) @(posedge clk_sys);
        #1;
        chk_flag(fetch_rom, 1'b1);
        chk_word(rom_size, 17'h10000);
        chk_flag(sel_valid, 1'b0);
        @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk_flag(sel_valid, 1'b0);
        @(posedge clk_sys);
        #1;
        check_sel(es, en, pm);
        @(posedge clk_sys);
        en_s  <= ~en;
        otp_p <= ~otp;
        field <= ~fld;
        strap <= ~st;
        repeat (3) @(posedge clk_sys);
        #1;
        check_sel(es, en, pm);
        chk_src(fw_src, es);
        chk_flag(fw_ok, 1'b1);
        chk_word(rom_size, 17'h10000);
    endtask

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Hang guard
    // ****************************************
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            fail_count++;
            print_verdict();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h80454A23));
        repeat (12) @(posedge clk_sys);
        for (int i = 0; i < 16; i++) begin
            run_case(1'b0, 1'b1, 4'(i), 4'($urandom));
        end
        for (int i = 0; i < 16; i++) begin
            run_case(1'b0, 1'b1, 4'h0, 4'(i));
        end
        run_case(1'b0, 1'b0, 4'h9, 4'h3);
        run_case(1'b1, 1'b1, 4'h2, 4'h1);
        for (int i = 0; i < 12; i++) begin
            run_case(1'($urandom), 1'($urandom), 4'($urandom), 4'($urandom));
        end
        print_verdict();
    end
endmodule
